// ---- verilog/cfh_regs.svh ----
/*
 * offsets, fields, reset values and timing counts of the card host interface.
 * assumes byte addresses, one 16-bit register a word.
 */
`ifndef CFH_REGS_SVH
`define CFH_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define CFH_OFS_CTRL     8'h00
`define CFH_OFS_PINS     8'h04
`define CFH_OFS_SRC      8'h08
`define CFH_OFS_IEN      8'h0c
`define CFH_OFS_PEND     8'h10
`define CFH_OFS_MISC     8'h14

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CFH_CTL_STB_EN   15
`define CFH_CTL_IDLE_HI  14
`define CFH_CTL_IDLE_LO  12
`define CFH_CTL_ACT_HI   11
`define CFH_CTL_ACT_LO   8
`define CFH_CTL_IO8      6
`define CFH_CTL_MEM8     5
`define CFH_CTL_PRE_EN   4
`define CFH_CTL_RST      3
`define CFH_CTL_EN       2
`define CFH_CTL_CLK_HI   1
`define CFH_CTL_CLK_LO   0
`define CFH_CTL_RESET    16'h1000
`define CFH_CTL_WMASK    16'hff7f

// ----------------------------------------------------------------
// pin, source and enable bits
// ----------------------------------------------------------------
`define CFH_BIT_IRQ_HI   8
`define CFH_BIT_IRQ_LO   6
`define CFH_BIT_CHG      4
`define CFH_BIT_CD2      1
`define CFH_BIT_CD1      0
`define CFH_IEN_WMASK    16'h0153
`define CFH_IEN_RESET    16'h0000
`define CFH_MISC_DUAL    0
`define CFH_MISC_RESET   16'h0000

// ----------------------------------------------------------------
// strobe and setup cycles per clock range, 00 = fastest clock
// ----------------------------------------------------------------
`define CFH_STB_R0       4'h7
`define CFH_STB_R1       4'h3
`define CFH_STB_R2       4'h1
`define CFH_STB_R3       4'h0
`define CFH_SET_R0       4'h3
`define CFH_SET_R1       4'h1
`define CFH_SET_R2       4'h0
`define CFH_SET_R3       4'h0
`define CFH_FILT_STAGES  4

`endif

// ---- verilog/cfh_pkg.sv ----
/*
 * types of the card host interface.
 * assumes nothing beyond the header of constants.
 */
package cfh_pkg;

   typedef enum logic [1:0] {
      CFH_SP_ATTR   = 2'h0,
      CFH_SP_COMMON = 2'h1,
      CFH_SP_IO     = 2'h2
   } cfh_space_t;

   // gray along idle, setup, strobe, hold, recover
   typedef enum logic [2:0] {
      CFH_ST_IDLE    = 3'h0,
      CFH_ST_SETUP   = 3'h1,
      CFH_ST_STROBE  = 3'h3,
      CFH_ST_HOLD    = 3'h2,
      CFH_ST_RECOVER = 3'h6
   } cfh_state_t;

   typedef struct packed {
      logic        write;
      cfh_space_t  space;
      logic [10:0] addr;
      logic [15:0] wdata;
   } cfh_req_t;

endpackage

// ---- verilog/cfh_filter.sv ----
/*
 * noise filter with change pulse for one detect input.
 * assumes an input synchronous to the clock.
 */
`timescale 1ns/1ps
module cfh_filter #(
   parameter int STAGES = 4
) (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   input  wire logic i_level,
   output logic      o_level,
   output logic      o_change
);
   logic [STAGES-1:0] hist_q;

   // ----------------------------------------------------------------
   // history of samples
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hist_q <= '0;
      end else begin
         hist_q <= {hist_q[STAGES-2:0], i_level};
      end
   end

   // ----------------------------------------------------------------
   // filtered level moves only after a stable run
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_level  <= 1'b0;
         o_change <= 1'b0;
      end else begin
         o_change <= 1'b0;
         if ((&hist_q) && !o_level) begin
            o_level  <= 1'b1;
            o_change <= 1'b1;
         end else if (!(|hist_q) && o_level) begin
            o_level  <= 1'b0;
            o_change <= 1'b1;
         end
      end
   end
endmodule

// ---- verilog/cfh_top.sv ----
/*
 * card host interface: registers, interrupt sources, card cycle engine.
 * drives enables, strobes, address and data.
 * assumes one-cycle register strobes, an access master that waits for
 * o_acc_ready, and card inputs synchronous to i_clk.
 */
// Our own choice: the address-and-strobe port.
// Behaviour
// R1: reset pin follows control bit 3.
// R2: control bit 2 low: no card cycles; a cycle already taken still completes.
// R3: bit 15 enables io strobe length; resets 0.
// R4: bits 14..12 idle cycles; reset 1.
// R5: bits 11..8 io strobe cycles, if bit 15.
// R6: bit 6: 8-bit io space.
// R7: bit 5: 8-bit common space.
// R8: bit 4: programmed io setup length.
// R9: bits 1..0 scale timing to clock range.
// R10: pin register live levels; detect bits filtered.
// R11: pin bit 6 inverted irq, bit 8 true.
// R12: source bits clear on write one.
// R13: source bit 8 high irq, bit 6 low irq.
// R14: source bit 4 is status change level.
// R15: detect change bits sticky on any edge.
// R16: enable register masks sources; resets 0.
// R17: pending is source AND enable.
// R18: misc bit 0: both enables on reads.
// R19: absent card inputs tied low.
// R20: reserved source bits read zero.
// R21: address, data, select, memory strobes driven.
// R22: buffer enable and direction follow cycle.
// R23: card wait low holds the strobe.
// R24: select low for attribute and io.
// R25: software uses 8 or 16-bit transfers.
// R26: memory spaces use oe/we, io io strobes.
// R27: 8-bit space one enable, 16-bit both.
`timescale 1ns/1ps
`include "cfh_regs.svh"
module cfh_top
   import cfh_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   output logic      [15:0] o_reg_rdata,
   input  wire logic        i_acc_valid,
   input  wire cfh_req_t    i_acc_req,
   output logic             o_acc_ready,
   output logic             o_acc_done,
   output logic      [15:0] o_acc_rdata,
   output logic             o_card_enable_low_n,
   output logic             o_card_enable_high_n,
   output logic             o_io_read_strobe_n,
   output logic             o_io_write_strobe_n,
   output logic             o_memory_output_enable_n,
   output logic             o_memory_write_enable_n,
   output logic             o_register_space_select_n,
   output logic      [10:0] o_card_address_bus,
   output logic      [15:0] o_card_data_bus,
   output logic             o_card_data_bus_oe_n,
   input  wire logic [15:0] i_card_data_bus,
   input  wire logic        i_card_wait_n,
   output logic             o_card_reset_out,
   input  wire logic        i_card_interrupt_in,
   input  wire logic        i_card_status_change_n,
   output logic             o_buffer_enable_n,
   output logic             o_buffer_direction
);
   logic [15:0] ctrl_q;
   logic [15:0] ien_q;
   logic [15:0] misc_q;
   logic [15:0] src_q;
   logic [15:0] src_d;
   logic        irq_q;
   logic        chg_n_q;
   logic        cd1_lvl;
   logic        cd2_lvl;
   logic        cd1_chg;
   logic        cd2_chg;
   logic [15:0] pins;
   logic [15:0] rd_mux;
   cfh_state_t  state_q;
   cfh_state_t  state_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   cfh_req_t    req_q;
   logic        take;
   logic        is_io;
   logic        narrow;
   logic [3:0]  stb_len;
   logic [3:0]  set_len;
   logic [3:0]  rng_stb;
   logic [3:0]  rng_set;
   logic [3:0]  act_len;
   logic        ena;

   assign ena  = ctrl_q[`CFH_CTL_EN];
   assign take = i_acc_valid && o_acc_ready;

   // ----------------------------------------------------------------
   // absent detect inputs, filtered so change logic is real
   // ----------------------------------------------------------------
   cfh_filter #(
      .STAGES (`CFH_FILT_STAGES)
   ) u_cd1 (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_level  (1'b0),               // [R19]
      .o_level  (cd1_lvl),
      .o_change (cd1_chg)
   );

   cfh_filter #(
      .STAGES (`CFH_FILT_STAGES)
   ) u_cd2 (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_level  (1'b0),               // [R19]
      .o_level  (cd2_lvl),
      .o_change (cd2_chg)
   );

   // ----------------------------------------------------------------
   // sampled card status inputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_q   <= 1'b0;
         chg_n_q <= 1'b1;
      end else begin
         irq_q   <= i_card_interrupt_in;
         chg_n_q <= i_card_status_change_n;
      end
   end

   always_comb begin
      pins = 16'h0000;                          // [R19]
      pins[`CFH_BIT_IRQ_HI] = irq_q;            // [R11]
      pins[`CFH_BIT_IRQ_LO] = ~irq_q;           // [R11]
      pins[`CFH_BIT_CHG]    = chg_n_q;          // [R10]
      pins[`CFH_BIT_CD2]    = cd2_lvl;          // [R10]
      pins[`CFH_BIT_CD1]    = cd1_lvl;          // [R10]
   end

   // ----------------------------------------------------------------
   // control, enable and misc registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= `CFH_CTL_RESET;              // [R3] [R4]
         ien_q  <= `CFH_IEN_RESET;              // [R16]
         misc_q <= `CFH_MISC_RESET;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            `CFH_OFS_CTRL: ctrl_q <= i_reg_wdata & `CFH_CTL_WMASK;
            `CFH_OFS_IEN:  ien_q  <= i_reg_wdata & `CFH_IEN_WMASK;
            `CFH_OFS_MISC: misc_q <= {15'h0000, i_reg_wdata[`CFH_MISC_DUAL]};
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt sources: a set in the clearing cycle survives
   // ----------------------------------------------------------------
   always_comb begin
      src_d = src_q;
      if (i_reg_wr && i_reg_addr == `CFH_OFS_SRC) begin
         src_d = src_q & ~i_reg_wdata;          // [R12]
      end
      if (ena && irq_q) begin
         src_d[`CFH_BIT_IRQ_HI] = 1'b1;         // [R13]
      end
      if (ena && !irq_q) begin
         src_d[`CFH_BIT_IRQ_LO] = 1'b1;         // [R13]
      end
      if (cd2_chg) begin
         src_d[`CFH_BIT_CD2] = 1'b1;            // [R15]
      end
      if (cd1_chg) begin
         src_d[`CFH_BIT_CD1] = 1'b1;            // [R15]
      end
      src_d[`CFH_BIT_CHG] = chg_n_q;            // [R14]
      src_d = src_d & `CFH_IEN_WMASK;           // [R20]
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         src_q <= 16'h0000;
      end else begin
         src_q <= src_d;
      end
   end

   // ----------------------------------------------------------------
   // register read port, data one cycle after strobe
   // ----------------------------------------------------------------
   always_comb begin
      case (i_reg_addr)
         `CFH_OFS_CTRL: rd_mux = ctrl_q;
         `CFH_OFS_PINS: rd_mux = pins;                  // [R10]
         `CFH_OFS_SRC:  rd_mux = src_q;                 // [R20]
         `CFH_OFS_IEN:  rd_mux = ien_q;
         `CFH_OFS_PEND: rd_mux = src_q & ien_q;         // [R17]
         `CFH_OFS_MISC: rd_mux = misc_q;
         default:       rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_reg_rdata <= 16'h0000;
      end else begin
         o_reg_rdata <= i_reg_rd ? rd_mux : 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // card reset follows its control bit
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_card_reset_out <= 1'b0;
      end else begin
         o_card_reset_out <= ctrl_q[`CFH_CTL_RST];       // [R1]
      end
   end

   // ----------------------------------------------------------------
   // cycle timing
   // ----------------------------------------------------------------
   assign is_io   = (req_q.space == CFH_SP_IO);
   assign narrow  = is_io ? ctrl_q[`CFH_CTL_IO8]         // [R6]
                          : ctrl_q[`CFH_CTL_MEM8];       // [R7]
   assign act_len = (ctrl_q[`CFH_CTL_ACT_HI:`CFH_CTL_ACT_LO] == 4'h0) ? 4'h0
                  : ctrl_q[`CFH_CTL_ACT_HI:`CFH_CTL_ACT_LO] - 4'h1;

   always_comb begin
      case (ctrl_q[`CFH_CTL_CLK_HI:`CFH_CTL_CLK_LO])         // [R9]
         2'h0:    begin rng_stb = `CFH_STB_R0; rng_set = `CFH_SET_R0; end
         2'h1:    begin rng_stb = `CFH_STB_R1; rng_set = `CFH_SET_R1; end
         2'h2:    begin rng_stb = `CFH_STB_R2; rng_set = `CFH_SET_R2; end
         default: begin rng_stb = `CFH_STB_R3; rng_set = `CFH_SET_R3; end
      endcase
   end

   // programmed io timing only when its enable bit is set
   assign stb_len = (is_io && ctrl_q[`CFH_CTL_STB_EN]) ? act_len : rng_stb;  // [R3] [R5]
   assign set_len = (is_io && ctrl_q[`CFH_CTL_PRE_EN]) ? act_len : rng_set;  // [R8]

   // ----------------------------------------------------------------
   // cycle state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         CFH_ST_IDLE: begin
            if (take) begin                              // [R2]
               state_d = CFH_ST_SETUP;
               cnt_d   = 4'h0;
            end
         end
         CFH_ST_SETUP: begin
            if (cnt_q >= set_len) begin
               state_d = CFH_ST_STROBE;
               cnt_d   = 4'h0;
            end else begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         CFH_ST_STROBE: begin
            if (cnt_q < stb_len) begin
               cnt_d = cnt_q + 4'h1;
            end else if (i_card_wait_n) begin            // [R23]
               state_d = CFH_ST_HOLD;
            end
         end
         CFH_ST_HOLD: begin
            cnt_d = 4'h0;
            if (ctrl_q[`CFH_CTL_IDLE_HI:`CFH_CTL_IDLE_LO] == 3'h0) begin
               state_d = CFH_ST_IDLE;
            end else begin
               state_d = CFH_ST_RECOVER;
            end
         end
         CFH_ST_RECOVER: begin
            if (cnt_q[2:0] >= ctrl_q[`CFH_CTL_IDLE_HI:`CFH_CTL_IDLE_LO] - 3'h1) begin
               state_d = CFH_ST_IDLE;                    // [R4]
            end else begin
               cnt_d = cnt_q + 4'h1;
            end
         end
         default: begin
            state_d = CFH_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_q <= CFH_ST_IDLE;
         cnt_q   <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         req_q <= '0;
      end else if (take) begin
         req_q <= i_acc_req;
      end
   end

   wire ena_nx = (i_reg_wr && i_reg_addr == `CFH_OFS_CTRL) ? i_reg_wdata[`CFH_CTL_EN] : ena;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_acc_ready <= 1'b0;
      end else begin
         o_acc_ready <= ena_nx && (state_d == CFH_ST_IDLE) && !take;  // [R2]
      end
   end

   // ----------------------------------------------------------------
   // read capture and completion
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_acc_done  <= 1'b0;
         o_acc_rdata <= 16'h0000;
      end else begin
         o_acc_done <= (state_q == CFH_ST_STROBE) && (state_d == CFH_ST_HOLD);
         if (state_q == CFH_ST_STROBE && state_d == CFH_ST_HOLD && !req_q.write) begin
            if (narrow) begin                            // [R27]
               o_acc_rdata <= {8'h00, i_card_data_bus[7:0]};
            end else begin
               o_acc_rdata <= i_card_data_bus;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // card pins, all registered; address, select and strobes from the next state, enables, buffer and data from both states
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_card_enable_low_n       <= 1'b1;
         o_card_enable_high_n      <= 1'b1;
         o_io_read_strobe_n        <= 1'b1;
         o_io_write_strobe_n       <= 1'b1;
         o_memory_output_enable_n  <= 1'b1;
         o_memory_write_enable_n   <= 1'b1;
         o_register_space_select_n <= 1'b1;
         o_card_address_bus        <= 11'h000;
         o_card_data_bus           <= 16'h0000;
         o_card_data_bus_oe_n      <= 1'b1;
         o_buffer_enable_n         <= 1'b1;
         o_buffer_direction        <= 1'b0;
      end else begin
         o_card_enable_low_n       <= 1'b1;
         o_card_enable_high_n      <= 1'b1;
         o_io_read_strobe_n        <= 1'b1;
         o_io_write_strobe_n       <= 1'b1;
         o_memory_output_enable_n  <= 1'b1;
         o_memory_write_enable_n   <= 1'b1;
         o_card_data_bus_oe_n      <= 1'b1;
         o_buffer_enable_n         <= 1'b1;
         if (state_d == CFH_ST_SETUP || state_d == CFH_ST_STROBE
             || state_d == CFH_ST_HOLD) begin
            o_card_address_bus        <= take ? i_acc_req.addr : req_q.addr;  // [R21]
            o_register_space_select_n <= (state_q == CFH_ST_IDLE)
               ? (i_acc_req.space == CFH_SP_COMMON)
               : (req_q.space == CFH_SP_COMMON);                              // [R24]
         end
         if (state_q != CFH_ST_IDLE && state_d != CFH_ST_RECOVER
             && state_d != CFH_ST_IDLE) begin
            o_card_enable_low_n  <= 1'b0;                                     // [R27]
            o_card_enable_high_n <= narrow && !(misc_q[`CFH_MISC_DUAL]
                                               && !req_q.write);              // [R18]
            o_buffer_enable_n    <= 1'b0;                                     // [R22]
            o_buffer_direction   <= req_q.write;                              // [R22]
            if (req_q.write) begin
               o_card_data_bus_oe_n <= 1'b0;                                  // [R21]
               o_card_data_bus      <= narrow ? {8'h00, req_q.wdata[7:0]}
                                              : req_q.wdata;
            end
         end
         if (state_d == CFH_ST_STROBE) begin
            if (is_io) begin
               o_io_read_strobe_n  <= req_q.write;                            // [R26]
               o_io_write_strobe_n <= !req_q.write;                           // [R26]
            end else begin
               o_memory_output_enable_n <= req_q.write;                       // [R26]
               o_memory_write_enable_n  <= !req_q.write;                      // [R26]
            end
         end
      end
   end
endmodule

// ---- verification/cfh_chk.sv ----
/*
 checker of cfh_top, on its ports.
 assumes one clock, async active-low reset.
*/
`timescale 1ns/1ps
module cfh_chk (
   input wire logic        i_clk, i_resetn, i_reg_wr, i_acc_valid, i_card_wait_n,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic        o_acc_ready, o_acc_done, o_card_enable_low_n, o_io_read_strobe_n,
   input wire logic        o_memory_output_enable_n, o_card_reset_out, o_buffer_enable_n,
   input wire logic        o_buffer_direction, o_io_write_strobe_n
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   wire ctl_wr = i_reg_wr && i_reg_addr == 8'h00;
   property p_rst_pin; ctl_wr |=> ##1 o_card_reset_out == $past(i_reg_wdata[3], 2);
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin off");
   property p_off; ctl_wr && !i_reg_wdata[2] |=> ##1 !o_acc_ready; endproperty
   a_off: assert property (p_off) else $error("ready while disabled");
   property p_done; i_acc_valid && o_acc_ready |-> ##[2:80] o_acc_done; endproperty
   a_done: assert property (p_done) else $error("no done");
   property p_iord; !o_io_read_strobe_n |-> !o_card_enable_low_n && !o_buffer_enable_n
      && !o_buffer_direction; endproperty
   a_iord: assert property (p_iord) else $error("read strobe setup");
   property p_iowr; !o_io_write_strobe_n |-> o_buffer_direction && !o_buffer_enable_n;
   endproperty
   a_iowr: assert property (p_iowr) else $error("write direction");
   property p_mem; !o_memory_output_enable_n |-> o_io_read_strobe_n && o_io_write_strobe_n;
   endproperty
   a_mem: assert property (p_mem) else $error("mixed strobes");
   property p_wait; !o_io_read_strobe_n && !i_card_wait_n |=> !o_io_read_strobe_n; endproperty
   a_wait: assert property (p_wait) else $error("wait ignored");
   property p_end; $rose(o_io_read_strobe_n) |-> o_acc_done; endproperty
   a_end: assert property (p_end) else $error("strobe end without done");
endmodule
bind cfh_top cfh_chk u_cfh_chk (.i_clk, .i_resetn, .i_reg_wr, .i_acc_valid, .i_card_wait_n,
   .i_reg_addr, .i_reg_wdata, .o_acc_ready, .o_acc_done, .o_card_enable_low_n,
   .o_io_read_strobe_n, .o_memory_output_enable_n, .o_card_reset_out, .o_buffer_enable_n,
   .o_buffer_direction, .o_io_write_strobe_n);

// ---- verification/cfh_card_model.sv ----
/*
 card model: read data follow address; wait for a set count.
 assumes cfh_top strobes on one clock.
*/
`timescale 1ns/1ps
module cfh_card_model (
   input  wire logic        i_clk,
   input  wire logic        i_rd_n,
   input  wire logic [10:0] i_addr,
   input  wire logic [3:0]  i_wait_cycles,
   output logic      [15:0] o_data,
   output logic             o_wait_n
);
   logic [15:0] last_q = 16'h0000;
   logic [3:0]  wcnt_q = 4'h0;
   logic        rd_q = 1'b0;
   wire         first = !i_rd_n && !rd_q && i_wait_cycles != 4'h0;
   // released bus shows its last value inverted
   assign o_data = i_rd_n ? ~last_q : {i_addr[7:0], ~i_addr[7:0]};
   assign o_wait_n = wcnt_q == 4'h0 && !first;
   always_ff @(posedge i_clk) begin
      rd_q <= !i_rd_n;
      last_q <= o_data;
      if (first) wcnt_q <= i_wait_cycles - 4'h1;
      else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q - 4'h1;
   end
endmodule

// ---- verification/testbench.sv ----
/*
 bench of cfh_top: registers, card cycles, interrupts.
 assumes the card model and the bound checker.
*/
`timescale 1ns/1ps
module testbench
   import cfh_pkg::*;
;
   logic        i_clk = 1'b0, i_resetn = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   logic        i_acc_valid = 1'b0, i_card_interrupt_in = 1'b1, i_card_status_change_n = 1'b1;
   logic [7:0]  i_reg_addr = 8'h00;
   logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata, o_acc_rdata, o_card_data_bus;
   logic [15:0] i_card_data_bus, card_q, wd, q;
   logic [10:0] o_card_address_bus;
   logic [3:0]  wcyc = 4'h0;
   logic        o_acc_ready, o_acc_done, o_card_enable_low_n, o_card_enable_high_n, hi_lo;
   logic        o_io_read_strobe_n, o_io_write_strobe_n, o_memory_output_enable_n, sel_lo;
   logic        o_memory_write_enable_n, o_register_space_select_n, o_card_data_bus_oe_n;
   logic        i_card_wait_n, o_card_reset_out, o_buffer_enable_n, o_buffer_direction;
   cfh_req_t    i_acc_req = '0;
   int          fails = 0, samples_checked = 0, cycles = 0, c, c0;
   cfh_top u_cfh_top (.i_clk, .i_resetn, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_acc_valid, .i_acc_req, .o_acc_ready, .o_acc_done, .o_acc_rdata,
      .o_card_enable_low_n, .o_card_enable_high_n, .o_io_read_strobe_n, .o_io_write_strobe_n,
      .o_memory_output_enable_n, .o_memory_write_enable_n, .o_register_space_select_n,
      .o_card_address_bus, .o_card_data_bus, .o_card_data_bus_oe_n, .i_card_data_bus,
      .i_card_wait_n, .o_card_reset_out, .i_card_interrupt_in, .i_card_status_change_n,
      .o_buffer_enable_n, .o_buffer_direction);
   cfh_card_model u_cfh_card_model (.i_clk, .i_rd_n(o_io_read_strobe_n & o_memory_output_enable_n),
      .i_addr(o_card_address_bus), .i_wait_cycles(wcyc), .o_data(card_q), .o_wait_n(i_card_wait_n));
   assign i_card_data_bus = o_card_data_bus_oe_n ? card_q : o_card_data_bus;
   always #25 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      if (!o_card_enable_low_n && !o_card_enable_high_n) hi_lo = 1'b1;
      if (!o_card_enable_low_n && !o_register_space_select_n) sel_lo = 1'b1;
      if (!o_io_write_strobe_n) wd = o_card_data_bus;
      cycles++;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_clk);
      chk("reg", o_reg_rdata, e);
   endtask
   task automatic acc(input logic w, input cfh_space_t s, input logic [10:0] a);
      i_acc_req <= '{w, s, a, 16'h5a0f};
      i_acc_valid <= 1'b1;
      @(posedge i_clk);
      while (o_acc_ready !== 1'b1) @(posedge i_clk);
      i_acc_valid <= 1'b0;
      hi_lo = 1'b0;
      sel_lo = 1'b0;
      c = 0;
      while (o_acc_done !== 1'b1) begin
         @(posedge i_clk);
         c++;
      end
      q = o_acc_rdata;
   endtask
   task automatic t_regs();
      rd(8'h04, 16'h0110);
      i_card_interrupt_in <= 1'b0;
      rd(8'h00, 16'h1000);
      rd(8'h0c, 16'h0000);
      rd(8'h10, 16'h0000);
      rd(8'h14, 16'h0000);
      rd(8'h18, 16'h0000);
      rd(8'h04, 16'h0050);
   endtask
   task automatic t_ctrl_off();
      wr(8'h00, 16'hffff);
      rd(8'h00, 16'hff7f);
      chk("rst", o_card_reset_out, 1);
      wr(8'h00, 16'h1003);
      i_acc_valid <= 1'b1;
      repeat (10) @(posedge i_clk);
      chk("ready", o_acc_ready, 0);
      chk("rst", o_card_reset_out, 0);
      i_acc_valid <= 1'b0;
   endtask
   task automatic t_timing();
      logic [15:0] ctl[6] = '{16'h1007, 16'h1004, 16'h1005, 16'h1006, 16'h9507, 16'h1517};
      int ext[6] = '{0, 10, 4, 1, 4, 4};
      for (int i = 0; i < 6; i++) begin
         wr(8'h00, ctl[i]);
         acc(1'b0, CFH_SP_IO, 11'h123);
         if (i == 0) c0 = c;
         chk("rdata", q, 16'h23dc);
         chk("cycles", 16'(c - c0), 16'(ext[i]));
      end
      wr(8'h00, 16'h1007);
      wcyc = 4'h3;
      acc(1'b0, CFH_SP_IO, 11'h123);
      chk("wait", 16'(c - c0), 16'h0003);
      wcyc = 4'h0;
   endtask
   task automatic t_width();
      wr(8'h00, 16'h1047);
      acc(1'b0, CFH_SP_IO, 11'h0a5);
      chk("io8", {q, hi_lo}, {16'h005a, 1'b0});
      acc(1'b0, CFH_SP_COMMON, 11'h0a5);
      chk("mem16", {q, hi_lo, sel_lo}, {16'ha55a, 2'h2});
      acc(1'b0, CFH_SP_ATTR, 11'h011);
      chk("attr", sel_lo, 1);
      acc(1'b1, CFH_SP_IO, 11'h011);
      chk("wdata", wd, 16'h000f);
      wr(8'h00, 16'h1027);
      wr(8'h14, 16'h0001);
      acc(1'b0, CFH_SP_COMMON, 11'h0a5);
      chk("dual", hi_lo, 1);
      rd(8'h14, 16'h0001);
      wr(8'h14, 16'h0000);
      acc(1'b0, CFH_SP_COMMON, 11'h0a5);
      chk("mem8", hi_lo, 0);
   endtask
   task automatic t_irq();
      i_card_interrupt_in <= 1'b1;
      wr(8'h0c, 16'hffff);
      rd(8'h0c, 16'h0153);
      wr(8'h08, 16'hffff);
      rd(8'h08, 16'h0110);
      wr(8'h0c, 16'h0100);
      i_card_interrupt_in <= 1'b0;
      rd(8'h10, 16'h0100);
      i_card_status_change_n <= 1'b0;
      wr(8'h08, 16'h0100);
      rd(8'h08, 16'h0050);
      wr(8'h08, 16'h0000);
      rd(8'h08, 16'h0040);
      rd(8'h10, 16'h0000);
   endtask
   task automatic stop_test();
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      @(posedge i_clk);
      t_regs();
      t_ctrl_off();
      t_timing();
      t_width();
      t_irq();
      stop_test();
   end
endmodule
